// [common/asr_pkg.sv]
// shared constants and types for the async sram host controller
package asr_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // timing, slowest speed grade so any grade is served
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_CYCLE_NS = 200;
  localparam int T_ACCESS_NS = 200;
  localparam int T_ADDR_SETUP_NS = 20;
  localparam int T_WRITE_PULSE_NS = 120;
  localparam int T_WRITE_RECOVERY_NS = 10;
  localparam int T_DATA_HOLD_NS = 10;
  localparam int T_OUT_DISABLE_NS = 60;
  localparam int DESELECT_TO_RETENTION_TIME_NS = 0;
  localparam int OPERATION_RECOVERY_TIME_NS = T_CYCLE_NS;

  // least times: round up, never below one cycle
  function automatic logic [7:0] ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[7:0];
  endfunction

  localparam logic [7:0] CYCLE_CYC = ceil_cyc(T_CYCLE_NS);
  localparam logic [7:0] ACCESS_CYC = ceil_cyc(T_ACCESS_NS);
  localparam logic [7:0] RD_SAMPLE_CYC = 8'(int'(ACCESS_CYC) + SYNC_STAGES + 1);
  localparam logic [7:0] SETUP_CYC = ceil_cyc(T_ADDR_SETUP_NS);
  localparam logic [7:0] PULSE_CYC = ceil_cyc(T_WRITE_PULSE_NS);
  localparam logic [7:0] HOLD_CYC = ceil_cyc((T_WRITE_RECOVERY_NS > T_DATA_HOLD_NS) ?
                                             T_WRITE_RECOVERY_NS : T_DATA_HOLD_NS);
  localparam logic [7:0] TURN_CYC = ceil_cyc(T_OUT_DISABLE_NS);
  localparam logic [7:0] RETAIN_SETUP_CYC = ceil_cyc(DESELECT_TO_RETENTION_TIME_NS);
  localparam logic [7:0] RECOVERY_CYC = ceil_cyc(OPERATION_RECOVERY_TIME_NS);

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } asr_pins_type;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asr_req_type;

  localparam asr_pins_type PINS_IDLE = '{addr: 11'h000, cs_n: 1'b1, oe_n: 1'b1,
                                         we_n: 1'b1, dq_out: 8'h00, dq_oe: 1'b0};

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE     = 9'b0_0000_0001,
    ST_RD_ACC   = 9'b0_0000_0010,
    ST_RD_END   = 9'b0_0000_0100,
    ST_WR_SETUP = 9'b0_0000_1000,
    ST_WR_PULSE = 9'b0_0001_0000,
    ST_WR_HOLD  = 9'b0_0010_0000,
    ST_PAD      = 9'b0_0100_0000,
    ST_RETAIN   = 9'b0_1000_0000,
    ST_RECOVER  = 9'b1_0000_0000
  } asr_state_type;

endpackage

// [hw/asr_sync.sv]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module asr_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // asr_sync

// [hw/asr_host.sv]
// host-side sequencer that drives a 2k x 8 asynchronous static ram
// Behaviour
// - write happens only in cs and we low overlap, held full pulse width
// - write recovery counted from first of cs or we rising before address changes
// - host never drives opposite data while ram drives around a write
// - host avoids driving data pins while selected ram drives them
// - we stays high for the whole of every read cycle
// - address valid no later than cs falling for a read
// - second write form keeps oe low throughout; host writes hold oe high throughout instead
// - ram deselected before supply drops into retention, no minimum delay
// - after supply returns keep ram deselected one read cycle time
`timescale 1ns/10ps
module asr_host
  import asr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // user request port
  input wire logic req_valid,
  input wire asr_req_type req,
  output logic req_ready,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  // retention control
  input wire logic retention_request,
  output logic retention_safe,
  // memory pins
  output asr_pins_type pins,
  input wire logic [DATA_W-1:0] dq_in
);

  // ----------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] dq_sync;

  asr_sync #(
    .WIDTH(DATA_W)
  ) u_dq_sync (
    .clock(clock),
    .nrst(nrst),
    .d(dq_in),
    .q(dq_sync)
  );

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  asr_state_type state;
  asr_state_type next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [7:0] cyc;
  logic [7:0] next_cyc;
  asr_pins_type next_pins;
  logic [DATA_W-1:0] next_rdata;
  logic next_done;
  logic next_ready;
  logic next_safe;

  always_comb begin
    next_state = state;
    next_cnt = (cnt != 8'h00) ? cnt - 8'h01 : cnt;
    next_cyc = (cyc != 8'hff) ? cyc + 8'h01 : cyc;
    next_pins = pins;
    next_rdata = rdata;
    next_done = 1'b0;
    next_ready = 1'b0;
    next_safe = 1'b0;
    case (state)
      ST_IDLE: begin
        next_pins = PINS_IDLE;
        if (retention_request) begin
          // cs is already high here, so retention may follow at once
          // deselect before retention
          next_state = ST_RETAIN;
          next_cnt = RETAIN_SETUP_CYC - 8'h01;
        end else if (req_valid && req_ready) begin
          next_cyc = 8'h01;
          next_pins.addr = req.addr;
          next_pins.dq_out = req.wdata;
          next_pins.cs_n = 1'b0;
          if (req.write) begin
            // cs falls before we; oe held high so the ram floats its pins
            // cs leads we
            next_pins.oe_n = 1'b1;
            next_pins.we_n = 1'b1;
            next_state = ST_WR_SETUP;
            next_cnt = SETUP_CYC - 8'h01;
          end else begin
            // address and cs change on the same edge
            // address with cs
            next_pins.oe_n = 1'b0;
            next_pins.we_n = 1'b1;
            next_pins.dq_oe = 1'b0;
            next_state = ST_RD_ACC;
            next_cnt = RD_SAMPLE_CYC - 8'h01;
          end
        end else begin
          next_ready = 1'b1;
        end
      end
      ST_RD_ACC: begin
        // access time plus synchroniser latency before sampling
        // wait access time
        if (cnt == 8'h00) begin
          next_rdata = dq_sync;
          next_pins.cs_n = 1'b1;
          next_pins.oe_n = 1'b1;
          next_state = ST_RD_END;
          next_cnt = TURN_CYC - 8'h01;
        end
      end
      ST_RD_END: begin
        // ram may still drive for the output disable time; host stays off
        // no bus contention
        if (cnt == 8'h00) begin
          next_state = ST_PAD;
        end
      end
      ST_WR_SETUP: begin
        if (cnt == 8'h00) begin
          // data driven from the start of the overlap until one cycle after it, while the ram floats
          // no opposing drive
          next_pins.we_n = 1'b0;
          next_pins.dq_oe = 1'b1;
          next_state = ST_WR_PULSE;
          next_cnt = PULSE_CYC - 8'h01;
        end
      end
      ST_WR_PULSE: begin
        if (cnt == 8'h00) begin
          next_pins.we_n = 1'b1;
          next_pins.cs_n = 1'b1;
          next_state = ST_WR_HOLD;
          next_cnt = HOLD_CYC - 8'h01;
        end
      end
      ST_WR_HOLD: begin
        // address and data held past the rising strobes
        // write recovery
        if (cnt == 8'h00) begin
          next_pins.dq_oe = 1'b0;
          next_state = ST_PAD;
        end
      end
      ST_PAD: begin
        // stretch short accesses to the full cycle time
        // cycle time
        if (cyc >= CYCLE_CYC) begin
          next_done = 1'b1;
          next_ready = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_RETAIN: begin
        next_pins = PINS_IDLE;
        next_safe = (cnt == 8'h00);
        if (!retention_request) begin
          next_safe = 1'b0;
          next_state = ST_RECOVER;
          next_cnt = RECOVERY_CYC - 8'h01;
        end
      end
      ST_RECOVER: begin
        // supply back; stay deselected one read cycle time
        // operation recovery
        next_pins = PINS_IDLE;
        if (cnt == 8'h00) begin
          next_ready = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_pins = PINS_IDLE;
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      cnt <= 8'h00;
      cyc <= 8'h00;
      pins <= PINS_IDLE;
      rdata <= 8'h00;
      done <= 1'b0;
      req_ready <= 1'b0;
      retention_safe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cyc <= next_cyc;
      pins <= next_pins;
      rdata <= next_rdata;
      done <= next_done;
      req_ready <= next_ready;
      retention_safe <= next_safe;
    end
  end

endmodule // asr_host

// [bench/asr_ram_model.sv]
// behavioural 2k x 8 asynchronous static ram on the host pins
`timescale 1ns/10ps
module asr_ram_model
  import asr_pkg::*;
#(
  parameter int ACC_NS = 20
) (
  // control and address pins
  input wire logic [ADDR_W-1:0] addr,
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic we_n,
  // data pins
  input wire logic [DATA_W-1:0] din,
  output logic [DATA_W-1:0] dq
);
  logic [DATA_W-1:0] mem [2048];
  logic [DATA_W-1:0] rd_late, wd;
  logic [ADDR_W-1:0] wa;
  logic armed = 1'b0;
  logic drive, on_late, echo;
  logic cs_first = 1'b0;
  // output only when selected, enabled and not writing
  // read data returns once the strobe rises
  assign drive = !cs_n && !oe_n && we_n;
  // written byte echoed only if select led the strobe
  always @(negedge we_n) cs_first = !cs_n;
  assign echo = !cs_n && !oe_n && !we_n && cs_first;
  // data valid only after the access time
  assign #(ACC_NS) rd_late = mem[addr];
  assign #(ACC_NS) on_late = drive;
  // floating pins show inverted data so a stale sample never passes
  assign dq = echo ? din : (drive && on_late) ? rd_late : ~mem[addr];
  // capture during overlap, commit at its end
  always @* if (!cs_n && !we_n) begin
    wa = addr;
    wd = din;
    armed = 1'b1;
  end
  always @(posedge cs_n or posedge we_n) if (armed) begin
    mem[wa] = wd;
    armed = 1'b0;
  end
endmodule // asr_ram_model

// [bench/asr_host_assertions.sv]
// timing checker for the sram host sequencer pins
`timescale 1ns/10ps
module asr_host_assertions
  import asr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // request side
  input wire logic req_valid,
  input wire asr_req_type req,
  input wire logic req_ready,
  input wire logic done,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic retention_request,
  input wire logic retention_safe,
  // memory pins
  input wire asr_pins_type pins,
  input wire logic [DATA_W-1:0] dq_in
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic take;
  // retention wins over a request in idle, so such a cycle takes nothing
  assign take = req_valid && req_ready && !retention_request;
  rd_start_a: assert property (take && !req.write |=>
    !pins.cs_n && !pins.oe_n && pins.we_n && pins.addr == $past(req.addr)) else $error("rd start");
  rd_end_a: assert property (take && !req.write |->
    ##1 !pins.cs_n ##22 !pins.cs_n ##1 pins.cs_n ##7 done) else $error("rd length");
  rd_we_a: assert property (!pins.oe_n |-> pins.we_n && !pins.cs_n) else $error("we in read");
  wr_start_a: assert property (take && req.write |=>
    !pins.cs_n && pins.oe_n && pins.we_n ##2 !pins.we_n && pins.dq_oe) else $error("wr start");
  wr_pulse_a: assert property ($fell(pins.we_n) |->
    (!pins.cs_n && !pins.we_n)[*8] ##1 (!pins.cs_n && !pins.we_n)[*4] ##1 (pins.cs_n && pins.we_n))
    else $error("wr pulse");
  wr_hold_a: assert property ($rose(pins.we_n) |->
    pins.dq_oe && $stable(pins.addr) ##1 !pins.dq_oe && $stable(pins.addr)) else $error("wr hold");
  dq_clash_a: assert property (pins.dq_oe |-> pins.oe_n) else $error("bus clash");
  ret_safe_a: assert property (retention_safe |-> pins.cs_n) else $error("selected");
  ret_exit_a: assert property ($fell(retention_safe) |->
    pins.cs_n throughout (##19 !req_ready ##1 req_ready)) else $error("recovery");
  cover property (take && req.write);
  cover property (take && !req.write);
  cover property ($fell(retention_safe));
endmodule // asr_host_assertions

// [bench/tb.sv]
// self-checking bench for the sram host sequencer
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end
module tb;
  import asr_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  asr_req_type req = '0;
  logic retention_request = 1'b0;
  logic slow = 1'b0;
  logic req_ready, done, retention_safe;
  logic [DATA_W-1:0] rdata, dq_in, dq_fast, dq_slow;
  asr_pins_type pins;
  int err_total = 0;
  int samples_checked = 0;
  logic [ADDR_W-1:0] at [4] = '{11'h000, 11'h7ff, 11'h555, 11'h2aa};
  logic [DATA_W-1:0] dt [4] = '{8'ha5, 8'h5a, 8'hff, 8'h00};
  always #5 clock = ~clock;
  // no pull on the data lines: whoever enables drives, else the selected model's pattern
  assign dq_in = pins.dq_oe ? pins.dq_out : (slow ? dq_slow : dq_fast);
  asr_host DUT (.clock(clock), .nrst(nrst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .rdata(rdata), .retention_request(retention_request),
    .retention_safe(retention_safe), .pins(pins), .dq_in(dq_in));
  asr_ram_model #(.ACC_NS(20)) ram_fast (.addr(pins.addr), .cs_n(pins.cs_n),
    .oe_n(pins.oe_n), .we_n(pins.we_n), .din(dq_in), .dq(dq_fast));
  asr_ram_model #(.ACC_NS(190)) ram_slow (.addr(pins.addr), .cs_n(pins.cs_n),
    .oe_n(pins.oe_n), .we_n(pins.we_n), .din(dq_in), .dq(dq_slow));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      err_total++;
      $display("[ERR] %0t wait ran out", $time);
      print_verdict();
    end
  endtask
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{write: wr, addr: a, wdata: d};
    do @(posedge clock); while (req_ready !== 1'b1 && ++n < 50);
    bound(n, 50);
    req_valid <= 1'b0;
    n = 0;
    do begin @(posedge clock); n++; end while (done !== 1'b1 && n < 60);
    bound(n, 60);
    `CHK(n, wr ? 21 : 31)
    if (!wr) `CHK(rdata, d)
  endtask
  task automatic t_write_read();
    for (int i = 0; i < 4; i++) access(1'b1, at[i], dt[i]);
    for (int i = 0; i < 4; i++) access(1'b0, at[i], dt[i]);
    $display("test write_read done");
  endtask
  // slow model's 190 ns answer still lands inside the fixed sample point
  task automatic t_slow_read();
    slow <= 1'b1;
    for (int i = 3; i >= 0; i--) access(1'b0, at[i], dt[i]);
    slow <= 1'b0;
    $display("test slow_read done");
  endtask
  task automatic t_retention();
    int n;
    n = 0;
    @(posedge clock);
    retention_request <= 1'b1;
    req_valid <= 1'b1;
    req <= '{write: 1'b1, addr: 11'h555, wdata: 8'h11};
    do @(posedge clock); while (retention_safe !== 1'b1 && ++n < 10);
    bound(n, 10);
    repeat (4) begin
      @(posedge clock);
      `CHK(pins.cs_n, 1'b1)
      `CHK(req_ready, 1'b0)
    end
    retention_request <= 1'b0;
    req_valid <= 1'b0;
    n = 0;
    do begin @(posedge clock); n++; end while (req_ready !== 1'b1 && n < 40);
    bound(n, 40);
    `CHK(n, 22)
    access(1'b0, 11'h555, 8'hff);
    $display("test retention done");
  endtask
  // reset lands after select but before the write strobe: nothing may be stored
  task automatic t_abort();
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{write: 1'b1, addr: 11'h000, wdata: 8'h3c};
    repeat (2) @(posedge clock);
    nrst <= 1'b0;
    req_valid <= 1'b0;
    #1 `CHK(pins, PINS_IDLE)
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    access(1'b0, 11'h000, 8'ha5);
    $display("test abort done");
  endtask
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    t_write_read();
    t_slow_read();
    t_retention();
    t_abort();
    print_verdict();
  end
endmodule // tb
bind asr_host asr_host_assertions chk (.clock(clock), .nrst(nrst), .req_valid(req_valid),
  .req(req), .req_ready(req_ready), .done(done), .rdata(rdata),
  .retention_request(retention_request), .retention_safe(retention_safe), .pins(pins),
  .dq_in(dq_in));
